// ### hdl/acfg_regs.sv
// Output configuration register bank with sample formatter
//
// Contract
// - Timing bit 3 selects normal or inverted output clock polarity.
// - Phase field delays output clock by 0, 1/8, 1/4 or 3/8 period.
// - Timing bit 0 turns the clock duty cycle stabilizer off or on.
// - Current field selects driver current per table; one code unused.
// - Termination bit enables termination and scales driver current by 1.6.
// - Output disable bit puts every digital output in high impedance.
// - Mode field selects full-rate CMOS, DDR LVDS or DDR CMOS.
// - Test field selects zeros, ones, checkerboard or alternating pattern.
// - Data format bit 2 turns alternate bit polarity coding off or on.
// - Data format bit 1 disables or enables the output randomizer.
// - Data format bit 0 selects offset binary or two's complement.
// - Alternate bit polarity forces offset binary output.
// - A selected test pattern overrides all other formatting.
// - Each access is a 16-bit word: read flag, address, data.
// - Software reset clears every mode control register to zero.
`timescale 1ns/1ps
`include "acfg_consts.svh"
module acfg_regs (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Serial configuration pins
   input  wire logic        cs_n,
   input  wire logic        sck,
   input  wire logic        sdi,
   output logic             sdo_out,
   output logic             sdo_oe,
   // Converter core samples
   input  wire logic [11:0] conv_sample,
   input  wire logic        conv_overflow,
   input  wire logic        conv_valid,
   // Formatted sample outputs
   output logic [11:0]      sample_data_out,
   output logic             overflow_flag_out,
   output logic             sample_valid_out,
   output logic             digital_out_oe,
   // Output clock control
   output logic             out_clock_invert,
   output logic [1:0]       out_clock_phase_sel,
   output logic             duty_stabilizer_en,
   output logic             phase_without_stabilizer,
   // Output driver control
   output logic [2:0]       diff_drive_current_sel,
   output logic             internal_termination_en,
   output logic [9:0]       drive_current_10ua,
   output logic             drive_current_valid,
   output logic [1:0]       output_standard_sel,
   output logic             std_cmos_full,
   output logic             std_lvds_ddr,
   output logic             std_cmos_ddr
);

   // ----------------------------------------
   // Serial port
   // ----------------------------------------
   acfg_if bus ();

   acfg_serial_port u_port (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .cs_n    (cs_n),
      .sck     (sck),
      .sdi     (sdi),
      .sdo_out (sdo_out),
      .sdo_oe  (sdo_oe),
      .bus     (bus)
   );

   // ----------------------------------------
   // Mode control registers
   // ----------------------------------------
   logic [7:0] timing_control_ff, nxt_timing_control;
   logic [7:0] output_mode_control_ff, nxt_output_mode_control;
   logic [7:0] data_format_control_ff, nxt_data_format_control;

   function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [7:0] t,
                                         input logic [7:0] m, input logic [7:0] f);
      logic [7:0] r;
      r = 8'h00;
      if (a == `ACFG_ADDR_TIMING) begin
         r = t;
      end else if (a == `ACFG_ADDR_OUT_MODE) begin
         r = m;
      end else if (a == `ACFG_ADDR_DATA_FORMAT) begin
         r = f;
      end
      return r;
   endfunction

   always_comb begin
      nxt_timing_control      = timing_control_ff;
      nxt_output_mode_control = output_mode_control_ff;
      nxt_data_format_control = data_format_control_ff;
      if (bus.wr_stb) begin
         if (bus.addr == `ACFG_ADDR_SW_RESET) begin
            if (bus.wdata[`ACFG_SW_RESET_BIT]) begin
               nxt_timing_control      = `ACFG_REG_RESET;
               nxt_output_mode_control = `ACFG_REG_RESET;
               nxt_data_format_control = `ACFG_REG_RESET;
            end
         end else if (bus.addr == `ACFG_ADDR_TIMING) begin
            nxt_timing_control = bus.wdata & `ACFG_TIMING_MASK;
         end else if (bus.addr == `ACFG_ADDR_OUT_MODE) begin
            nxt_output_mode_control = bus.wdata & `ACFG_OUT_MODE_MASK;
         end else if (bus.addr == `ACFG_ADDR_DATA_FORMAT) begin
            nxt_data_format_control = bus.wdata & `ACFG_DATA_FORMAT_MASK;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         timing_control_ff      <= `ACFG_REG_RESET;
         output_mode_control_ff <= `ACFG_REG_RESET;
         data_format_control_ff <= `ACFG_REG_RESET;
      end else begin
         timing_control_ff      <= nxt_timing_control;
         output_mode_control_ff <= nxt_output_mode_control;
         data_format_control_ff <= nxt_data_format_control;
      end
   end

   assign bus.rdata = rd_mux(bus.addr, timing_control_ff, output_mode_control_ff,
                             data_format_control_ff);

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   logic       alt_pol_en;
   logic       scram_en;
   logic       twos_en;
   logic [2:0] test_sel;

   assign out_clock_invert       = timing_control_ff[`ACFG_CLK_INV_BIT];
   assign out_clock_phase_sel    = timing_control_ff[`ACFG_CLK_PHASE_HI:`ACFG_CLK_PHASE_LO];
   assign duty_stabilizer_en     = timing_control_ff[`ACFG_STAB_BIT];
   assign phase_without_stabilizer = (out_clock_phase_sel != 2'h0) && !duty_stabilizer_en;
   assign diff_drive_current_sel = output_mode_control_ff[`ACFG_CUR_HI:`ACFG_CUR_LO];
   assign internal_termination_en = output_mode_control_ff[`ACFG_TERM_BIT];
   assign digital_out_oe         = !output_mode_control_ff[`ACFG_OUT_OFF_BIT];
   assign output_standard_sel    = output_mode_control_ff[`ACFG_STD_HI:`ACFG_STD_LO];
   assign std_cmos_full          = output_standard_sel == acfg_pkg::STD_CMOS_FULL;
   assign std_lvds_ddr           = output_standard_sel == acfg_pkg::STD_LVDS_DDR;
   assign std_cmos_ddr           = output_standard_sel == acfg_pkg::STD_CMOS_DDR;
   assign test_sel               = data_format_control_ff[`ACFG_TEST_HI:`ACFG_TEST_LO];
   assign alt_pol_en             = data_format_control_ff[`ACFG_ALT_POL_BIT];
   assign scram_en               = data_format_control_ff[`ACFG_SCRAM_BIT];
   assign twos_en                = data_format_control_ff[`ACFG_TWOS_BIT];

   // ----------------------------------------
   // Driver current
   // ----------------------------------------
   function automatic logic [9:0] base_current(input logic [2:0] sel);
      logic [9:0] c;
      c = 10'h000;
      case (sel)
         3'h0: c = `ACFG_CUR_000;
         3'h1: c = `ACFG_CUR_001;
         3'h2: c = `ACFG_CUR_010;
         3'h4: c = `ACFG_CUR_100;
         3'h5: c = `ACFG_CUR_101;
         3'h6: c = `ACFG_CUR_110;
         3'h7: c = `ACFG_CUR_111;
         default: c = 10'h000;
      endcase
      return c;
   endfunction

   logic [9:0]  cur_ff, nxt_cur;
   logic        cur_ok_ff, nxt_cur_ok;
   logic [12:0] cur_wide;

   always_comb begin
      cur_wide   = {3'h0, base_current(diff_drive_current_sel)};
      nxt_cur_ok = diff_drive_current_sel != 3'h3;
      if (internal_termination_en) begin
         cur_wide = (cur_wide * `ACFG_TERM_MUL) / `ACFG_TERM_DIV;
      end
      nxt_cur = cur_wide[9:0];
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cur_ff    <= 10'h000;
         cur_ok_ff <= 1'h0;
      end else begin
         cur_ff    <= nxt_cur;
         cur_ok_ff <= nxt_cur_ok;
      end
   end

   assign drive_current_10ua  = cur_ff;
   assign drive_current_valid = cur_ok_ff;

   // ----------------------------------------
   // Sample formatter
   // ----------------------------------------
   function automatic logic [12:0] fmt_sample(input logic [11:0] raw, input logic ovf,
                                             input logic [2:0] tp, input logic alt,
                                             input logic rnd, input logic twos,
                                             input logic odd);
      logic [11:0] d;
      logic        o;
      d = raw;
      o = ovf;
      if (twos && !alt) begin
         d = d ^ `ACFG_MSB_MASK;
      end
      if (rnd) begin
         d = {d[11:1] ^ {11{d[0]}}, d[0]};
      end
      if (alt) begin
         d = d ^ `ACFG_ALT_POL_MASK;
      end
      case (tp)
         acfg_pkg::TP_ZEROS: begin
            d = 12'h000;
            o = 1'h0;
         end
         acfg_pkg::TP_ONES: begin
            d = 12'hFFF;
            o = 1'h1;
         end
         acfg_pkg::TP_CHECKER: begin
            d = odd ? `ACFG_CHECKER_B : `ACFG_CHECKER_A;
            o = !odd;
         end
         acfg_pkg::TP_ALTER: begin
            d = odd ? 12'h000 : 12'hFFF;
            o = !odd;
         end
         default: begin
            o = ovf;
         end
      endcase
      return {o, d};
   endfunction

   logic [11:0] data_ff, nxt_data;
   logic        ovf_ff, nxt_ovf;
   logic        vld_ff, nxt_vld;
   logic        odd_ff, nxt_odd;

   always_comb begin
      nxt_data = data_ff;
      nxt_ovf  = ovf_ff;
      nxt_vld  = conv_valid;
      nxt_odd  = odd_ff;
      if (conv_valid) begin
         {nxt_ovf, nxt_data} = fmt_sample(conv_sample, conv_overflow, test_sel, alt_pol_en,
                                          scram_en, twos_en, odd_ff);
         nxt_odd = !odd_ff;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         data_ff <= 12'h000;
         ovf_ff  <= 1'h0;
         vld_ff  <= 1'h0;
         odd_ff  <= 1'h0;
      end else begin
         data_ff <= nxt_data;
         ovf_ff  <= nxt_ovf;
         vld_ff  <= nxt_vld;
         odd_ff  <= nxt_odd;
      end
   end

   assign sample_data_out   = data_ff;
   assign overflow_flag_out = ovf_ff;
   assign sample_valid_out  = vld_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_write(logic [6:0] a);
      bus.wr_stb && bus.addr == a;
   endsequence

   sequence s_plain_sample;
      conv_valid && test_sel == 3'h0;
   endsequence

   a_sw_reset_clears: assert property (
      s_write(`ACFG_ADDR_SW_RESET) ##0 bus.wdata[7] |=>
      timing_control_ff == 8'h00 && output_mode_control_ff == 8'h00
      && data_format_control_ff == 8'h00)
      else $error("software reset left a register set");

   a_stab_follows: assert property (
      s_write(`ACFG_ADDR_TIMING) |=> duty_stabilizer_en == $past(bus.wdata[0]))
      else $error("stabilizer enable does not follow timing write");

   a_clk_inv_follows: assert property (
      s_write(`ACFG_ADDR_TIMING) |=> out_clock_invert == $past(bus.wdata[3])
      && out_clock_phase_sel == $past(bus.wdata[2:1]))
      else $error("clock invert or phase does not follow timing write");

   a_out_off_hiz: assert property (
      s_write(`ACFG_ADDR_OUT_MODE) ##0 bus.wdata[2] |=> !digital_out_oe)
      else $error("outputs still enabled after disable write");

   a_term_scale: assert property (
      internal_termination_en && diff_drive_current_sel == 3'h0 ##1
      $stable(output_mode_control_ff) |-> drive_current_10ua == 10'h230)
      else $error("terminated current not scaled by 1.6");

   a_test_zeros: assert property (
      conv_valid && test_sel == acfg_pkg::TP_ZEROS |=>
      sample_data_out == 12'h000 && !overflow_flag_out && sample_valid_out)
      else $error("zero pattern not forced");

   a_alt_pol_offset: assert property (
      s_plain_sample ##0 alt_pol_en && !scram_en |=>
      sample_data_out == ($past(conv_sample) ^ `ACFG_ALT_POL_MASK))
      else $error("alternate polarity output not offset binary");

   a_twos_msb: assert property (
      s_plain_sample ##0 twos_en && !alt_pol_en && !scram_en |=>
      sample_data_out == ($past(conv_sample) ^ `ACFG_MSB_MASK))
      else $error("two's complement msb not inverted");

   a_read_keeps: assert property (
      !bus.wr_stb |=> $stable(timing_control_ff) && $stable(output_mode_control_ff)
      && $stable(data_format_control_ff))
      else $error("register changed without a write");

endmodule

// ### common/acfg_consts.svh
// Register map, field positions, reset values and code tables of the output configuration bank
`ifndef ACFG_CONSTS_SVH
`define ACFG_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ACFG_ADDR_SW_RESET     7'h00
`define ACFG_ADDR_TIMING       7'h02
`define ACFG_ADDR_OUT_MODE     7'h03
`define ACFG_ADDR_DATA_FORMAT  7'h04

// ----------------------------------------
// Reset values and implemented bit masks
// ----------------------------------------
`define ACFG_REG_RESET         8'h00
`define ACFG_TIMING_MASK       8'h0F
`define ACFG_OUT_MODE_MASK     8'h7F
`define ACFG_DATA_FORMAT_MASK  8'h3F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACFG_SW_RESET_BIT      7
`define ACFG_CLK_INV_BIT       3
`define ACFG_CLK_PHASE_HI      2
`define ACFG_CLK_PHASE_LO      1
`define ACFG_STAB_BIT          0
`define ACFG_CUR_HI            6
`define ACFG_CUR_LO            4
`define ACFG_TERM_BIT          3
`define ACFG_OUT_OFF_BIT       2
`define ACFG_STD_HI            1
`define ACFG_STD_LO            0
`define ACFG_TEST_HI           5
`define ACFG_TEST_LO           3
`define ACFG_ALT_POL_BIT       2
`define ACFG_SCRAM_BIT         1
`define ACFG_TWOS_BIT          0

// ----------------------------------------
// Serial word and data path constants
// ----------------------------------------
`define ACFG_WORD_BITS         5'h10
`define ACFG_HEAD_BITS         5'h08
`define ACFG_MSB_MASK          12'h800
`define ACFG_ALT_POL_MASK      12'hAAA
`define ACFG_CHECKER_A         12'hAAA
`define ACFG_CHECKER_B         12'h555

// ----------------------------------------
// Driver current in 10 uA units
// ----------------------------------------
`define ACFG_CUR_000           10'h15E
`define ACFG_CUR_001           10'h190
`define ACFG_CUR_010           10'h1C2
`define ACFG_CUR_100           10'h12C
`define ACFG_CUR_101           10'h0FA
`define ACFG_CUR_110           10'h0D2
`define ACFG_CUR_111           10'h0AF
`define ACFG_TERM_MUL          13'h0008
`define ACFG_TERM_DIV          13'h0005

`endif

// ### common/acfg_pkg.sv
// Types shared by the output configuration bank
package acfg_pkg;

   // ----------------------------------------
   // Serial port states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_SHIFT = 3'h2,
      ST_HOLD  = 3'h4
   } acfg_sp_state_t;

   // ----------------------------------------
   // Test pattern codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      TP_OFF     = 3'h0,
      TP_ZEROS   = 3'h1,
      TP_ONES    = 3'h3,
      TP_CHECKER = 3'h5,
      TP_ALTER   = 3'h7
   } acfg_test_t;

   // ----------------------------------------
   // Output standard codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      STD_CMOS_FULL = 2'h0,
      STD_LVDS_DDR  = 2'h1,
      STD_CMOS_DDR  = 2'h2,
      STD_UNUSED    = 2'h3
   } acfg_std_t;

endpackage

// ### common/acfg_if.sv
// Register access carrier between serial port and register bank
`timescale 1ns/1ps
interface acfg_if;
   logic       wr_stb;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport port (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ### hdl/acfg_serial_port.sv
// Serial 16-bit word port: pin synchronisers, write strobe and open-drain read back
`timescale 1ns/1ps
`include "acfg_consts.svh"
module acfg_serial_port (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Serial pins
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic sdi,
   output logic      sdo_out,
   output logic      sdo_oe,
   // Register access
   acfg_if.port      bus
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] cs_sync_ff;
   logic [2:0] sck_sync_ff;
   logic [1:0] sdi_sync_ff;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cs_sync_ff  <= 2'h3;
         sck_sync_ff <= 3'h0;
         sdi_sync_ff <= 2'h0;
      end else begin
         cs_sync_ff  <= {cs_sync_ff[0], cs_n};
         sck_sync_ff <= {sck_sync_ff[1:0], sck};
         sdi_sync_ff <= {sdi_sync_ff[0], sdi};
      end
   end

   logic sel;
   logic sck_rise;
   logic sck_fall;
   assign sel      = !cs_sync_ff[1];
   assign sck_rise = sck_sync_ff[1] && !sck_sync_ff[2];
   assign sck_fall = !sck_sync_ff[1] && sck_sync_ff[2];

   // ----------------------------------------
   // Word shifter
   // ----------------------------------------
   acfg_pkg::acfg_sp_state_t state_ff, nxt_state;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic       rw_ff, nxt_rw;
   logic [6:0] addr_ff, nxt_addr;
   logic [7:0] wdata_ff, nxt_wdata;
   logic       wr_ff, nxt_wr;
   logic       load_ff, nxt_load;
   logic       rd_act_ff, nxt_rd_act;
   logic [7:0] sdo_sh_ff, nxt_sdo_sh;

   always_comb begin
      nxt_state  = state_ff;
      nxt_cnt    = cnt_ff;
      nxt_shift  = shift_ff;
      nxt_rw     = rw_ff;
      nxt_addr   = addr_ff;
      nxt_wdata  = wdata_ff;
      nxt_wr     = 1'h0;
      nxt_load   = 1'h0;
      nxt_rd_act = rd_act_ff;
      nxt_sdo_sh = sdo_sh_ff;
      case (state_ff)
         acfg_pkg::ST_IDLE: begin
            nxt_cnt    = 5'h00;
            nxt_rd_act = 1'h0;
            if (sel) begin
               nxt_state = acfg_pkg::ST_SHIFT;
            end
         end
         acfg_pkg::ST_SHIFT: begin
            if (!sel) begin
               nxt_state = acfg_pkg::ST_IDLE;
            end else if (sck_rise) begin
               nxt_shift = {shift_ff[6:0], sdi_sync_ff[1]};
               nxt_cnt   = cnt_ff + 5'h01;
               if (cnt_ff == `ACFG_HEAD_BITS - 5'h01) begin
                  nxt_rw   = shift_ff[6];
                  nxt_addr = {shift_ff[5:0], sdi_sync_ff[1]};
                  nxt_load = 1'h1;
               end
               if (cnt_ff == `ACFG_WORD_BITS - 5'h01) begin
                  nxt_state = acfg_pkg::ST_HOLD;
                  nxt_wdata = {shift_ff[6:0], sdi_sync_ff[1]};
                  nxt_wr    = !rw_ff;
               end
            end
         end
         acfg_pkg::ST_HOLD: begin
            if (!sel) begin
               nxt_state = acfg_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = acfg_pkg::ST_IDLE;
         end
      endcase
      if (load_ff && rw_ff && sel) begin
         nxt_rd_act = 1'h1;
         nxt_sdo_sh = bus.rdata;
      end else if (rd_act_ff && sck_fall && cnt_ff > `ACFG_HEAD_BITS) begin
         nxt_sdo_sh = {sdo_sh_ff[6:0], 1'h1};
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff  <= acfg_pkg::ST_IDLE;
         cnt_ff    <= 5'h00;
         shift_ff  <= 8'h00;
         rw_ff     <= 1'h0;
         addr_ff   <= 7'h00;
         wdata_ff  <= 8'h00;
         wr_ff     <= 1'h0;
         load_ff   <= 1'h0;
         rd_act_ff <= 1'h0;
         sdo_sh_ff <= 8'hFF;
      end else begin
         state_ff  <= nxt_state;
         cnt_ff    <= nxt_cnt;
         shift_ff  <= nxt_shift;
         rw_ff     <= nxt_rw;
         addr_ff   <= nxt_addr;
         wdata_ff  <= nxt_wdata;
         wr_ff     <= nxt_wr;
         load_ff   <= nxt_load;
         rd_act_ff <= nxt_rd_act;
         sdo_sh_ff <= nxt_sdo_sh;
      end
   end

   assign bus.wr_stb = wr_ff;
   assign bus.addr   = addr_ff;
   assign bus.wdata  = wdata_ff;
   assign sdo_out    = 1'h0;
   assign sdo_oe     = rd_act_ff && sel && !sdo_sh_ff[7];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_count_capped: assert property (@(posedge clk_sys) disable iff (!rstn)
      cnt_ff <= `ACFG_WORD_BITS)
      else $error("serial bit count passed sixteen");

   a_write_on_last: assert property (@(posedge clk_sys) disable iff (!rstn)
      wr_ff |-> $past(cnt_ff) == `ACFG_WORD_BITS - 5'h01 && !rw_ff && cnt_ff == `ACFG_WORD_BITS)
      else $error("write strobe not on sixteenth bit of a write word");

endmodule

// ### verif/acfg_host_model.sv
// Host model driving the serial configuration port
`timescale 1ns/1ps
module acfg_host_model (
   // Clock
   input  wire logic clk_sys,
   // Serial pins
   input  wire logic sdo,
   output logic      cs_n,
   output logic      sck,
   output logic      sdi
);
   initial begin
      cs_n = 1'h1;
      sck = 1'h0;
      sdi = 1'h0;
   end
   task automatic step(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Flag, address, data, MSB first; fewer than 16 bits aborts
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      cs_n = 1'h0;
      step(3);
      for (int i = 15; i >= 16 - nbits; i--) begin
         sdi = w[i];
         step(6);
         if (i < 8) rd = {rd[6:0], sdo};
         sck = 1'h1;
         step(6);
         sck = 1'h0;
      end
      sdi = ~sdi;
      step(6);
      cs_n = 1'h1;
      step(6);
   endtask
endmodule

// ### verif/test_acfg_regs.sv
// Self-checking bench of the output configuration bank
`timescale 1ns/1ps
module test_acfg_regs;
   logic        clk_sys = 1'h0;
   logic        rstn = 1'h0;
   logic        cs_n, sck, sdi, sdo_out, sdo_oe, conv_overflow, conv_valid;
   logic        overflow_flag_out, sample_valid_out, digital_out_oe, out_clock_invert;
   logic        duty_stabilizer_en, phase_without_stabilizer, internal_termination_en;
   logic        drive_current_valid, std_cmos_full, std_lvds_ddr, std_cmos_ddr, ph;
   logic [11:0] conv_sample, sample_data_out;
   logic [9:0]  drive_current_10ua;
   logic [2:0]  diff_drive_current_sel;
   logic [1:0]  out_clock_phase_sel, output_standard_sel;
   logic [7:0]  t, m, f, r;
   int          n_tests, miscompares, cycles;
   wire         sdo = sdo_oe ? sdo_out : 1'h1;
   acfg_regs acfg_regs_i (.*);
   acfg_host_model acfg_host_model_i (.clk_sys, .sdo, .cs_n, .sck, .sdi);
   always #12.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("tests=%0d miscompares=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      acfg_host_model_i.xfer({1'h0, a, d}, 16, r);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      acfg_host_model_i.xfer({1'h1, a, 8'h00}, 16, r);
      chk(r, e);
   endtask
   function automatic int cur(input logic [7:0] g);
      int tab[8] = '{350, 400, 450, 0, 300, 250, 210, 175};
      return g[3] ? tab[g[6:4]] * 8 / 5 : tab[g[6:4]];
   endfunction
   task automatic chk_cfg;
      chk(out_clock_invert, t[3]);
      chk(out_clock_phase_sel, t[2:1]);
      chk(duty_stabilizer_en, t[0]);
      chk(phase_without_stabilizer, t[2:1] != 2'h0 && !t[0]);
      chk(diff_drive_current_sel, m[6:4]);
      chk({drive_current_valid, drive_current_10ua}, {m[6:4] != 3'h3, 10'(cur(m))});
      chk(internal_termination_en, m[3]);
      chk(digital_out_oe, !m[2]);
      chk({output_standard_sel, std_cmos_full, std_lvds_ddr, std_cmos_ddr},
          {m[1:0], m[1:0] == 2'h0, m[1:0] == 2'h1, m[1:0] == 2'h2});
   endtask
   task automatic samp(input logic [11:0] s, input logic o);
      logic [11:0] d;
      logic        eo;
      eo = o;
      d = s ^ ((f[0] && !f[2]) ? 12'h800 : 12'h000);
      if (f[1]) d[11:1] = d[11:1] ^ {11{d[0]}};
      if (f[2]) d = d ^ 12'hAAA;
      case (f[5:3])
         3'h1: {eo, d} = 13'h0000;
         3'h3: {eo, d} = 13'h1FFF;
         3'h5: {eo, d} = ph ? 13'h0555 : 13'h1AAA;
         3'h7: {eo, d} = ph ? 13'h0000 : 13'h1FFF;
         default: ;
      endcase
      conv_sample = s;
      conv_overflow = o;
      conv_valid = 1'h1;
      @(negedge clk_sys);
      conv_valid = 1'h0;
      ph = !ph;
      chk({sample_valid_out, overflow_flag_out, sample_data_out}, {1'h1, eo, d});
   endtask
   initial begin
      conv_sample = 12'h000;
      conv_overflow = 1'h0;
      conv_valid = 1'h0;
      t = 8'h00;
      m = 8'h00;
      f = 8'h00;
      ph = 1'h0;
      void'($urandom(32'h6CED));
      repeat (2) @(negedge clk_sys);
      rstn = 1'b1;
      @(negedge clk_sys);
      chk_cfg();
      for (int i = 0; i < 16; i++) begin
         t = 8'($urandom);
         if (t[2:1] != 2'h0) t[0] = 1'h1;
         m = 8'($urandom);
         m[6:4] = i[2:0];
         m[3] = i[3];
         m[1:0] = i[3:2];
         f = 8'($urandom);
         f[5:3] = i[3:1];
         if (i < 2) f[2:0] = i[0] ? 3'h5 : 3'h1;
         wr(7'h02, t);
         wr(7'h03, m);
         wr(7'h04, f);
         rd(7'h02, t & 8'h0F);
         rd(7'h03, m & 8'h7F);
         rd(7'h04, f & 8'h3F);
         chk_cfg();
         repeat (3) samp(12'($urandom), 1'($urandom));
      end
      acfg_host_model_i.xfer({1'h0, 7'h02, 8'h0F}, 10, r);
      rd(7'h02, t & 8'h0F);
      wr(7'h05, 8'hFF);
      rd(7'h05, 8'h00);
      wr(7'h00, 8'h80);
      t = 8'h00;
      m = 8'h00;
      f = 8'h00;
      chk_cfg();
      rd(7'h04, 8'h00);
      give_verdict();
   end
endmodule
